/* File: hw/lem_map_engine.sv */
// module: duty and mapping execution for three led engines
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module lem_map_engine
    import lem_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [ENG_N-1:0] instr_valid,
    input wire logic [ENG_N-1:0][15:0] instr,
    output logic [ENG_N-1:0] instr_ready,
    output logic [ENG_N-1:0] instr_done,
    output logic [ENG_N-1:0] instr_unhandled,
    output logic [ENG_N-1:0] eng_rst_req,
    input wire logic [ENG_N-1:0][7:0] var_a,
    input wire logic [ENG_N-1:0][7:0] var_b,
    input wire logic [7:0] var_c,
    input wire logic [7:0] var_d,
    output logic sram_rd_en,
    output logic [6:0] sram_addr,
    input wire logic [15:0] sram_rdata,
    output logic [CH_N-1:0][DUTY_W-1:0] ch_duty,
    output logic [CH_N-1:0] ch_owned,
    output logic [ENG_N-1:0] fader_en
);

    // instruction word classification, shared by all three engines
    function automatic lem_op_t lem_decode(input logic [15:0] w);
        lem_op_t op;
        op = OP_OTHER;
        if (w[15:8] == OPC_SETPWM)
            op = OP_SETPWM;
        else if (w[15:2] == OPC_SETVAR)
            op = OP_SETVAR;
        else if (!w[15] && w[8:0] == 9'h000)
            op = (w[14:9] == 6'h00) ? OP_RST : OP_WAIT;
        else if (w[15:10] == OPC_MAP_PFX)
        begin
            case (w[9:7])
                SUB_LD_START: op = OP_LD_START;
                SUB_MAP_START: op = OP_MAP_START;
                SUB_LD_END: op = OP_LD_END;
                SUB_MAP_SEL: op = OP_MAP_SEL;
                SUB_LD_ADDR: op = OP_LD_ADDR;
                SUB_MAP_ADDR: op = OP_MAP_ADDR;
                SUB_STEP:
                    case (w[6:0])
                        STEP_NEXT: op = OP_MAP_NEXT;
                        STEP_PREV: op = OP_MAP_PREV;
                        STEP_LD_NEXT: op = OP_LD_NEXT;
                        STEP_LD_PREV: op = OP_LD_PREV;
                        default: op = OP_OTHER;
                    endcase
                default: op = OP_OTHER;
            endcase
        end
        return op;
    endfunction : lem_decode

    // one-hot channel for a select value, none outside 1..9
    function automatic logic [CH_N-1:0] lem_sel_mask(input logic [6:0] sel);
        logic [CH_N-1:0] m;
        m = 9'h000;
        if (sel >= SEL_MIN && sel <= SEL_MAX)
            m = 9'(9'h001 << (sel - SEL_MIN));
        return m;
    endfunction : lem_sel_mask

    // owning engine of a channel: {valid, index}, lowest index wins
    function automatic logic [2:0] lem_owner(input logic [ENG_N-1:0][CH_N-1:0] m, input int c);
        logic [2:0] r;
        r = 3'h0;
        for (int e = ENG_N - 1; e >= 0; e--)
            if (m[e][c])
                r = {1'h1, 2'(e)};
        return r;
    endfunction : lem_owner

    logic [11:0] div_ff;
    logic mtick_ff;
    logic ap_rd_ff;
    logic ap_wr_ff;
    logic ap_ok_ff;
    logic [7:0] ap_idx_ff;
    logic [31:0] hrdata_ff;
    logic [31:0] rd_val;
    logic take;
    logic bus_wr;
    logic [ENG_N-1:0][CH_N-1:0] map_mask;
    logic [ENG_N-1:0] set_req;
    logic [ENG_N-1:0][7:0] set_val;
    logic [ENG_N-1:0] want;
    logic [ENG_N-1:0][6:0] want_addr;
    logic [ENG_N-1:0] gnt;
    logic [6:0] gnt_addr;
    logic rd_ff;
    logic [6:0] addr_ff;
    logic [CH_N-1:0][DUTY_W-1:0] duty_ff;

    // master clock enable pulse
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            div_ff <= 12'h000;
            mtick_ff <= 1'h0;
        end
        else if (div_ff == MCLK_DIV_M1)
        begin
            div_ff <= 12'h000;
            mtick_ff <= 1'h1;
        end
        else
        begin
            div_ff <= div_ff + 12'h001;
            mtick_ff <= 1'h0;
        end
    end

    // address phase; odd accesses answer okay, ignored
    assign take = hsel & hready & htrans[1];

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ap_rd_ff <= 1'h0;
            ap_wr_ff <= 1'h0;
            ap_ok_ff <= 1'h0;
            ap_idx_ff <= 8'h00;
        end
        else if (hready)
        begin
            ap_rd_ff <= take & ~hwrite;
            ap_wr_ff <= take & hwrite;
            ap_ok_ff <= (hsize == HSIZE_WORD) & (haddr[31:10] == 22'h000000) & (haddr[1:0] == 2'h0);
            ap_idx_ff <= haddr[9:2];
        end
        else
        begin
            // read wait ends; hrdata loads on this edge
            ap_rd_ff <= 1'h0;
        end
    end

    // one read wait state so a prior write is visible
    assign hreadyout = ~ap_rd_ff;
    assign hresp = 1'h0;
    assign hrdata = hrdata_ff;
    assign bus_wr = ap_wr_ff & ap_ok_ff & hready;

    // register read mux
    always_comb
    begin
        rd_val = 32'h00000000;
        if (ap_ok_ff && ap_idx_ff >= IDX_MAP_BASE && ap_idx_ff <= IDX_MAP_LAST)
        begin
            for (int e = 0; e < ENG_N; e++)
            begin
                if (ap_idx_ff == IDX_MAP_BASE + 8'(2 * e))
                    rd_val = {30'h00000000, fader_en[e], map_mask[e][CH_N-1]};
                if (ap_idx_ff == IDX_MAP_BASE + 8'(2 * e + 1))
                    rd_val = {24'h000000, map_mask[e][7:0]};
            end
        end
        else if (ap_ok_ff && ap_idx_ff >= IDX_DUTY_BASE && ap_idx_ff <= IDX_DUTY_LAST)
        begin
            for (int c = 0; c < CH_N; c++)
                if (ap_idx_ff == IDX_DUTY_BASE + 8'(c))
                    rd_val = {24'h000000, duty_ff[c][DUTY_W-1:DUTY_FRAC_W]};
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            hrdata_ff <= 32'h00000000;
        else if (ap_rd_ff)
            hrdata_ff <= rd_val;
    end

    // row read arbiter: lowest engine first
    always_comb
    begin
        gnt = 3'h0;
        gnt_addr = 7'h00;
        for (int e = 0; e < ENG_N; e++)
            if (want[e] && gnt == 3'h0)
            begin
                gnt[e] = 1'h1;
                gnt_addr = want_addr[e];
            end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rd_ff <= 1'h0;
            addr_ff <= 7'h00;
        end
        else
        begin
            rd_ff <= |gnt;
            addr_ff <= gnt_addr;
        end
    end

    assign sram_rd_en = rd_ff;
    assign sram_addr = addr_ff;

    // one execution engine per loop index, three per instance
    for (genvar e = 0; e < ENG_N; e++)
    begin : g_eng
        lem_st_t st_ff;
        lem_op_t op;
        logic [6:0] start_ff;
        logic [6:0] end_ff;
        logic [6:0] ptr_ff;
        logic [6:0] fad_ff;
        logic [CH_N-1:0] mask_ff;
        logic fader_ff;
        logic [13:0] hold_ff;
        logic done_ff;
        logic unh_ff;
        logic rstq_ff;
        logic [6:0] nxt_fwd;
        logic [6:0] nxt_back;
        logic [6:0] oper;
        logic [13:0] wait_ticks;

        assign op = lem_decode(instr[e]);
        assign oper = instr[e][6:0];
        assign nxt_fwd = (ptr_ff == end_ff) ? start_ff : ptr_ff + 7'h01;
        assign nxt_back = (ptr_ff == start_ff) ? end_ff : ptr_ff - 7'h01;
        assign wait_ticks = instr[e][14] ? 14'({instr[e][13:9], 9'h000}) : 14'({instr[e][13:9], 4'h0});

        // duty push only on an accepted duty instruction
        assign set_req[e] = (st_ff == ST_IDLE) & instr_valid[e] & ((op == OP_SETPWM) | (op == OP_SETVAR));
        always_comb
        begin
            set_val[e] = instr[e][7:0];
            if (op == OP_SETVAR)
            begin
                case (instr[e][1:0])
                    2'h0: set_val[e] = var_a[e];
                    2'h1: set_val[e] = var_b[e];
                    2'h2: set_val[e] = var_c;
                    default: set_val[e] = var_d;
                endcase
            end
        end

        assign want[e] = (st_ff == ST_FETCH);
        assign want_addr[e] = fad_ff;
        assign map_mask[e] = mask_ff;
        assign fader_en[e] = fader_ff;
        assign instr_ready[e] = (st_ff == ST_IDLE);
        assign instr_done[e] = done_ff;
        assign instr_unhandled[e] = unh_ff;
        assign eng_rst_req[e] = rstq_ff;

        always_ff @(posedge ref_clk or posedge rst)
        begin
            if (rst)
            begin
                st_ff <= ST_IDLE;
                start_ff <= 7'h00;
                end_ff <= 7'h00;
                ptr_ff <= 7'h00;
                fad_ff <= 7'h00;
                mask_ff <= 9'h000;
                fader_ff <= 1'h0;
                hold_ff <= 14'h0000;
                done_ff <= 1'h0;
                unh_ff <= 1'h0;
                rstq_ff <= 1'h0;
            end
            else
            begin
                done_ff <= 1'h0;
                unh_ff <= 1'h0;
                rstq_ff <= 1'h0;
                unique case (st_ff)
                    ST_IDLE:
                        if (instr_valid[e])
                        begin
                            hold_ff <= INSTR_TICKS;
                            st_ff <= ST_HOLD;
                            case (op)
                                OP_SETPWM, OP_SETVAR: st_ff <= ST_HOLD;
                                OP_WAIT:
                                    hold_ff <= wait_ticks;
                                OP_RST:
                                begin
                                    rstq_ff <= 1'h1;
                                    done_ff <= 1'h1;
                                    st_ff <= ST_IDLE;
                                end
                                OP_LD_START: start_ff <= oper;
                                OP_LD_END: end_ff <= oper;
                                OP_LD_ADDR: ptr_ff <= oper;
                                OP_LD_NEXT: ptr_ff <= nxt_fwd;
                                OP_LD_PREV: ptr_ff <= nxt_back;
                                OP_MAP_SEL:
                                begin
                                    mask_ff <= lem_sel_mask(oper);
                                    fader_ff <= 1'h0;
                                end
                                OP_MAP_START:
                                begin
                                    start_ff <= oper;
                                    ptr_ff <= oper;
                                    fad_ff <= oper;
                                    st_ff <= ST_FETCH;
                                end
                                OP_MAP_ADDR:
                                begin
                                    ptr_ff <= oper;
                                    fad_ff <= oper;
                                    st_ff <= ST_FETCH;
                                end
                                OP_MAP_NEXT:
                                begin
                                    ptr_ff <= nxt_fwd;
                                    fad_ff <= nxt_fwd;
                                    st_ff <= ST_FETCH;
                                end
                                OP_MAP_PREV:
                                begin
                                    ptr_ff <= nxt_back;
                                    fad_ff <= nxt_back;
                                    st_ff <= ST_FETCH;
                                end
                                default:
                                begin
                                    // ramps, branches, arithmetic run elsewhere
                                    unh_ff <= 1'h1;
                                    done_ff <= 1'h1;
                                    st_ff <= ST_IDLE;
                                end
                            endcase
                        end
                    ST_FETCH:
                        if (gnt[e])
                            st_ff <= ST_ISSUE;
                    ST_ISSUE:
                        st_ff <= ST_LOAD;
                    ST_LOAD:
                    begin
                        // row sets connections and fader enable; outputs wait for duty
                        mask_ff <= sram_rdata[CH_N-1:0];
                        fader_ff <= sram_rdata[ROW_FADER_BIT];
                        hold_ff <= INSTR_TICKS;
                        st_ff <= ST_HOLD;
                    end
                    ST_HOLD:
                        if (mtick_ff)
                        begin
                            if (hold_ff <= 14'h0001)
                            begin
                                done_ff <= 1'h1;
                                st_ff <= ST_IDLE;
                            end
                            else
                                hold_ff <= hold_ff - 14'h0001;
                        end
                    default:
                        st_ff <= ST_IDLE;
                endcase
            end
        end
    end

    // duty store: owner engine wins, bus writes reach unowned channels
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            duty_ff <= {CH_N{12'h000}};
        else
        begin
            for (int c = 0; c < CH_N; c++)
            begin
                logic [2:0] own;
                own = lem_owner(map_mask, c);
                if (own[2])
                begin
                    if (set_req[own[1:0]])
                        duty_ff[c] <= {set_val[own[1:0]], DUTY_FRAC_ZERO};
                end
                else if (bus_wr && ap_idx_ff == IDX_DUTY_BASE + 8'(c))
                    duty_ff[c] <= {hwdata[7:0], DUTY_FRAC_ZERO};
            end
        end
    end

    // ownership flags for the driver side
    always_comb
    begin
        for (int c = 0; c < CH_N; c++)
        begin
            logic [2:0] own;
            own = lem_owner(map_mask, c);
            ch_owned[c] = own[2];
        end
    end

    assign ch_duty = duty_ff;

endmodule : lem_map_engine

/* File: hw/lem_pkg.sv */
// package: constants and types for the led engine block
// Behaviour
// - direct duty instruction loads mapped channels from its low eight bits, no ramp
// - direct duty instruction lasts sixteen master clock cycles before the next one
// - variable duty form: selector 0 local A, 1 local B, 2 global C, 3 global D
// - during a pause the engine waits and leaves every duty it controls unchanged
// - pause with prescale and time both zero runs as the reset instruction
// - pause prescale 0 ticks every 16 master cycles, prescale 1 every 512
// - pause lasts the five-bit time field times the selected prescale tick
// - mapping rows live in lower program memory, addressed by seven-bit absolute address
// - each of three engines may drive any subset of the nine channels
// - on a shared channel engine 1 beats engines 2 and 3, engine 2 beats 3
// - activating instructions move the pointer and apply the row; pointer-only ones just move
// - mapping rows and fader enables read at 70h to 75h, never written by the bus
// - an engine-mapped channel ignores bus duty writes until the engine maps elsewhere
// - remapping alone never changes an output; only a duty instruction or a bus duty write to an unmapped channel does
// - a released channel keeps the last engine value as its duty
// - duty is 12 bits; instructions and registers see the upper 8 bits
// - row bits 8 to 0 select channels 8 to 0, bit 9 enables the engine fader
// - start, end and pointer loads leave connections alone; prefix 100111, seven-bit address
// - stepping past end wraps to start, stepping back past start wraps to end
// - single select connects one channel for values 1 to 9, otherwise none
package lem_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int MCLK_HZ = 32_768;
    localparam int MCLK_DIV = CLK_HZ / MCLK_HZ;
    localparam logic [11:0] MCLK_DIV_M1 = 12'(MCLK_DIV - 1);
    localparam int ENG_N = 3;
    localparam int CH_N = 9;
    localparam int DUTY_W = 12;
    localparam int DUTY_FRAC_W = 4;
    localparam logic [3:0] DUTY_FRAC_ZERO = 4'h0;
    // durations in master ticks
    localparam logic [13:0] INSTR_TICKS = 14'h0010;
    localparam int PRE0_SHIFT = 4;
    localparam int PRE1_SHIFT = 9;
    // opcode fields
    localparam logic [7:0] OPC_SETPWM = 8'h40;
    localparam logic [13:0] OPC_SETVAR = 14'h2118;
    localparam logic [5:0] OPC_MAP_PFX = 6'h27;
    localparam logic [2:0] SUB_LD_START = 3'h4;
    localparam logic [2:0] SUB_MAP_START = 3'h0;
    localparam logic [2:0] SUB_LD_END = 3'h1;
    localparam logic [2:0] SUB_MAP_SEL = 3'h2;
    localparam logic [2:0] SUB_STEP = 3'h3;
    localparam logic [2:0] SUB_LD_ADDR = 3'h6;
    localparam logic [2:0] SUB_MAP_ADDR = 3'h7;
    localparam logic [6:0] STEP_NEXT = 7'h00;
    localparam logic [6:0] STEP_PREV = 7'h40;
    localparam logic [6:0] STEP_LD_NEXT = 7'h01;
    localparam logic [6:0] STEP_LD_PREV = 7'h41;
    localparam logic [6:0] SEL_MIN = 7'h01;
    localparam logic [6:0] SEL_MAX = 7'h09;
    localparam int ROW_FADER_BIT = 9;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_MAP_BASE = 8'h70;
    localparam logic [7:0] IDX_MAP_LAST = 8'h75;
    localparam logic [7:0] IDX_DUTY_BASE = 8'h40;
    localparam logic [7:0] IDX_DUTY_LAST = 8'h48;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [3:0] {
        OP_SETPWM = 4'h0, OP_SETVAR = 4'h1, OP_WAIT = 4'h2, OP_RST = 4'h3,
        OP_LD_START = 4'h4, OP_MAP_START = 4'h5, OP_LD_END = 4'h6, OP_MAP_SEL = 4'h7,
        OP_MAP_NEXT = 4'h8, OP_MAP_PREV = 4'h9, OP_LD_NEXT = 4'hA, OP_LD_PREV = 4'hB,
        OP_LD_ADDR = 4'hC, OP_MAP_ADDR = 4'hD, OP_OTHER = 4'hE
    } lem_op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0, ST_FETCH = 3'h1, ST_ISSUE = 3'h2, ST_LOAD = 3'h3, ST_HOLD = 3'h4
    } lem_st_t;
endpackage : lem_pkg

/* File: sim/lem_map_engine_properties.sv */
// checker: properties on the block ports
`timescale 1ns/1ps
module lem_map_engine_properties
    import lem_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [ENG_N-1:0] instr_valid,
    input wire logic [ENG_N-1:0][15:0] instr,
    input wire logic [ENG_N-1:0] instr_ready,
    input wire logic [ENG_N-1:0] instr_done,
    input wire logic [ENG_N-1:0] instr_unhandled,
    input wire logic [ENG_N-1:0] eng_rst_req,
    input wire logic sram_rd_en,
    input wire logic [6:0] sram_addr,
    input wire logic [CH_N-1:0][DUTY_W-1:0] ch_duty,
    input wire logic [ENG_N-1:0] fader_en
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic wr_dp_ff;
    logic [ENG_N-1:0] take_ff;
    int span_ff;
    logic low_any;
    wire logic [ENG_N-1:0] take = instr_valid & instr_ready;
    // bus write data phase marker
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            wr_dp_ff <= 1'b0;
        else if (hready)
            wr_dp_ff <= hsel & htrans[1] & hwrite;
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            take_ff <= '0;
        else
            take_ff <= take;
    // engine 1 busy span
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            span_ff <= 0;
        else if (take[0])
            span_ff <= 1;
        else
            span_ff <= span_ff + 1;
    always_comb
    begin
        low_any = 1'b0;
        for (int c = 0; c < CH_N; c++)
            low_any = low_any | (|ch_duty[c][3:0]);
    end
    a_rst_on_zero: assert property (take[0] && instr[0] == 16'h0000 |=> eng_rst_req[0] && instr_done[0])
        else $error("zero word did not run as reset");
    a_duty_low_zero: assert property (!low_any)
        else $error("duty fraction bits not zero");
    a_duty_on_cause: assert property (!$stable(ch_duty) |-> $past(wr_dp_ff) || (|take_ff) || $past(|take_ff))
        else $error("duty changed without instruction or write");
    a_done_min_span: assert property (instr_done[0] && !eng_rst_req[0] && !instr_unhandled[0] |-> span_ff >= 15 * MCLK_DIV)
        else $error("done too early");
    a_ready_after_done: assert property (instr_done[0] |->
        instr_ready[0] && (take_ff[0] || !$past(instr_ready[0])))
        else $error("ready not restored after done");
    a_row_addr_read: assert property (take[0] && instr[0][15:7] == 9'h13F |-> ##[1:12] sram_rd_en && sram_addr == instr[0][6:0])
        else $error("row not fetched");
    a_fader_from_row: assert property ($rose(fader_en[0]) |-> $past(sram_rd_en, 2) || $past(sram_rd_en, 3))
        else $error("fader set without row read");
    a_read_one_wait: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read data phase not one wait");
    c_rst_word: cover property (eng_rst_req[0]);
    c_row_read: cover property (sram_rd_en);
    c_bus_read: cover property (hsel && htrans[1] && !hwrite);
endmodule : lem_map_engine_properties

/* File: sim/lem_sram_model.sv */
// partner: program memory with mapping rows
`timescale 1ns/1ps
module lem_sram_model
    import lem_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sram_rd_en,
    input wire logic [6:0] sram_addr,
    output logic [15:0] sram_rdata
);
    logic [15:0] rows [128];
    logic [15:0] last_ff;
    // row 5: fader, channels 0 and 1; others empty
    initial
    begin
        foreach (rows[i])
            rows[i] = 16'h0000;
        rows[5] = 16'h0203;
    end
    // data one cycle after strobe; flips otherwise to expose stale reads
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            last_ff <= 16'hA5A5;
        else if (sram_rd_en)
            last_ff <= rows[sram_addr];
        else
            last_ff <= ~last_ff;
    assign sram_rdata = last_ff;
endmodule : lem_sram_model

/* File: sim/test_led_engine_pwm_and_mapping_ops.sv */
// testbench: duty, mapping and register tests
`timescale 1ns/1ps
module test_led_engine_pwm_and_mapping_ops
    import lem_pkg::*;
;
    logic ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready, rd_dp = 1'b0;
    logic hreadyout, hresp, sram_rd_en;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, seed = 32'h000138D2, rnd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [ENG_N-1:0] instr_valid = '0, instr_ready, instr_done, instr_unhandled, eng_rst_req, fader_en;
    logic [ENG_N-1:0][15:0] instr = '0;
    logic [ENG_N-1:0][7:0] var_a = '0, var_b = '0;
    logic [7:0] var_c = 8'h00, var_d = 8'h00;
    logic [7:0] dexp [CH_N];
    logic [31:0] mexp [6] = '{32'h2, 32'h3, 32'h0, 32'h1, 32'h1, 32'h0};
    logic [6:0] sram_addr;
    logic [15:0] sram_rdata;
    logic [CH_N-1:0][DUTY_W-1:0] ch_duty;
    logic [CH_N-1:0] ch_owned;
    logic [31:0] exp_q[$];
    int err_total = 0, checked = 0;
    assign hready = hreadyout;
    lem_map_engine u_dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .instr_valid(instr_valid), .instr(instr),
        .instr_ready(instr_ready), .instr_done(instr_done), .instr_unhandled(instr_unhandled),
        .eng_rst_req(eng_rst_req), .var_a(var_a), .var_b(var_b), .var_c(var_c), .var_d(var_d),
        .sram_rd_en(sram_rd_en), .sram_addr(sram_addr), .sram_rdata(sram_rdata), .ch_duty(ch_duty),
        .ch_owned(ch_owned), .fader_en(fader_en));
    lem_sram_model u_mem (.ref_clk(ref_clk), .rst(rst), .sram_rd_en(sram_rd_en), .sram_addr(sram_addr),
        .sram_rdata(sram_rdata));
    initial
        forever #5 ref_clk = ~ref_clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
            err_total++;
        end
    endtask : chk
    // one word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_dp <= !w;
        do @(posedge ref_clk); while (hready !== 1'b1);
        rd_dp <= 1'b0;
    endtask : bus
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd
    // k = {reset request, unhandled}; 0 is full length
    task automatic issue(input int e, input logic [15:0] w, input logic [1:0] k);
        int n;
        @(posedge ref_clk);
        instr[e] <= w;
        instr_valid[e] <= 1'b1;
        do @(posedge ref_clk); while (instr_ready[e] !== 1'b1);
        instr_valid[e] <= 1'b0;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (instr_done[e] !== 1'b1);
        chk("instr flags", 32'(k), 32'({eng_rst_req[e], instr_unhandled[e]}));
        if (k == 2'b00)
            chk("long span", 32'h1, 32'(n >= 15 * MCLK_DIV && n <= 16 * MCLK_DIV + 8));
        else
            chk("short span", 32'h1, 32'(n));
    endtask : issue
    // reads matched in order against the notes
    always @(posedge ref_clk)
        if (rd_dp && hready === 1'b1)
        begin
            chk("hrdata", exp_q.size() > 0 ? exp_q[0] : 32'hDEADBEEF, hrdata);
            void'(exp_q.pop_front());
        end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        repeat (100000) @(posedge ref_clk);
        err_total++;
        print_verdict();
    end
    initial
    begin
        seed = xs(seed);
        var_d <= seed[7:0];
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        fork
            issue(0, 16'h0000, 2'b10);
            issue(1, 16'h0210, 2'b01);
            issue(2, 16'hA001, 2'b01);
        join
        $display("test decode done");
        // engine 1 row 5 (ch0, ch1, fader), engine 2 sel 1 (ch0), engine 3 sel 9 (ch8)
        fork
            issue(0, 16'h9F85, 2'b00);
            issue(1, 16'h9D01, 2'b00);
            issue(2, 16'h9D09, 2'b00);
        join
        for (int c = 0; c < CH_N; c++)
            chk("ch_duty after map", 32'h0, 32'(ch_duty[c]));
        chk("ch_owned", 32'h103, 32'(ch_owned));
        chk("fader_en", 32'h1, 32'(fader_en));
        for (int i = 0; i < 6; i++)
            rd(32'h1C0 + 32'(4 * i), mexp[i]);
        bus(1'b1, 32'h1C4, 32'h1FF);
        rd(32'h1C4, 32'h3);
        rd(32'h400, 32'h0);
        $display("test mapping done");
        seed = xs(seed);
        rnd = {24'h0, seed[7:0]};
        bus(1'b1, 32'h100, 32'h77);
        bus(1'b1, 32'h110, rnd);
        rd(32'h100, 32'h0);
        rd(32'h110, rnd);
        $display("test bus duty done");
        fork
            issue(0, 16'h40AA, 2'b00);
            issue(1, 16'h4055, 2'b00);
            issue(2, 16'h8463, 2'b00);
        join
        foreach (dexp[c])
            dexp[c] = 8'h00;
        dexp[0] = 8'hAA;
        dexp[1] = 8'hAA;
        dexp[4] = rnd[7:0];
        dexp[8] = var_d;
        for (int c = 0; c < CH_N; c++)
            chk("ch_duty", 32'({dexp[c], 4'h0}), 32'(ch_duty[c]));
        rd(32'h100, 32'hAA);
        rd(32'h120, 32'(var_d));
        $display("test duty done");
        @(posedge ref_clk);
        print_verdict();
    end
endmodule : test_led_engine_pwm_and_mapping_ops
bind lem_map_engine lem_map_engine_properties u_props (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .instr_valid(instr_valid),
    .instr(instr), .instr_ready(instr_ready), .instr_done(instr_done), .instr_unhandled(instr_unhandled),
    .eng_rst_req(eng_rst_req), .sram_rd_en(sram_rd_en), .sram_addr(sram_addr), .ch_duty(ch_duty),
    .fader_en(fader_en));
